// >>> logic/dtd_pkg.sv
// Shared constants, register ids and field decoders of the DSP data transfer decoder
//
// Contract
// - Single pointer codes pick R4, R5, R2, R3
// - Single register field maps to DSP registers
// - X pointer R4/R5, X0/X1 load, A0/A1 store
// - Arithmetic source and destination field decoding
// - Upper half bits 16-31, lower 0-15
// - Word load fills upper half, zeroes lower
// - Word store writes the register upper half
// - Longword moves 32 bits, step four
// - Accumulator load sign-extends into guard bits
// - Guard store drives data bits 0-7
// - Word post-increment adds two, pre-decrement subtracts
// - Indexed update adds X index after access
// - X memory transfers are word only
// - X mode bits pick indirect, increment, index
// - Same word also carries a Y transfer
// - Condition flag untouched by data transfers
// - X and Y use their own buses
// - X and Y transfers are always unconditional
// - Single transfers use the shared load bus
// - X mode zero makes no X access
`default_nettype none
package dtd_pkg;
    localparam logic [5:0] PFX_PAR   = 6'h3c;
    localparam logic [5:0] PFX_SGL   = 6'h3d;
    localparam logic [1:0] MODE_PRE  = 2'h0;
    localparam logic [1:0] MODE_IND  = 2'h1;
    localparam logic [1:0] MODE_POST = 2'h2;
    localparam logic [1:0] MODE_IDX  = 2'h3;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG = 32'h0000_0004;
    localparam logic [31:0] RST_DATA  = 32'h0000_0000;
    localparam logic [7:0]  RST_GUARD = 8'h00;
    localparam logic        RST_DC    = 1'b0;
    localparam int PFX_LSB = 10;
    localparam int SGL_AA_LSB = 8;
    localparam int SGL_DS_LSB = 4;
    localparam int SGL_MODE_LSB = 2;
    localparam int SGL_SIZE_BIT = 1;
    localparam int SGL_DIR_BIT = 0;
    localparam int X_PTR_BIT = 9;
    localparam int Y_PTR_BIT = 8;
    localparam int X_REG_BIT = 7;
    localparam int Y_REG_BIT = 6;
    localparam int X_DIR_BIT = 5;
    localparam int Y_DIR_BIT = 4;
    localparam int X_MODE_LSB = 2;
    localparam int Y_MODE_LSB = 0;
    localparam int ALU_SX_LSB = 6;
    localparam int ALU_SY_LSB = 4;
    localparam int ALU_DZ_LSB = 0;

    typedef enum logic [3:0] {
        R_X0 = 4'h0, R_X1 = 4'h1, R_Y0 = 4'h2, R_Y1 = 4'h3,
        R_M0 = 4'h4, R_M1 = 4'h5, R_A0 = 4'h6, R_A1 = 4'h7,
        R_A0G = 4'h8, R_A1G = 4'h9, R_NONE = 4'hf
    } dtd_reg_e;

    function automatic dtd_reg_e ds_decode(input logic [3:0] code);
        case (code)
            4'h5: ds_decode = R_A1;
            4'h7: ds_decode = R_A0;
            4'h8: ds_decode = R_X0;
            4'h9: ds_decode = R_X1;
            4'ha: ds_decode = R_Y0;
            4'hb: ds_decode = R_Y1;
            4'hc: ds_decode = R_M0;
            4'hd: ds_decode = R_A1G;
            4'he: ds_decode = R_M1;
            4'hf: ds_decode = R_A0G;
            default: ds_decode = R_NONE;
        endcase
    endfunction : ds_decode
endpackage : dtd_pkg
`default_nettype wire

// >>> logic/dtd_field_decode.sv
// Operand field decoding for single, X, Y and arithmetic fields
`default_nettype none
module dtd_field_decode
    import dtd_pkg::*;
(
    input  wire logic [15:0] instr,
    input  wire logic [15:0] op_word,
    output dtd_reg_e         sgl_reg,
    output logic [2:0]       sgl_ptr,
    output logic [2:0]       x_ptr,
    output dtd_reg_e         x_reg,
    output logic [2:0]       y_ptr,
    output dtd_reg_e         y_reg,
    output dtd_reg_e         alu_sx,
    output dtd_reg_e         alu_sy,
    output dtd_reg_e         alu_dz
);
    logic [1:0] aa;
    dtd_reg_e   dz_raw;

    always_comb begin
        aa = instr[SGL_AA_LSB +: 2];
        unique case (aa)
            2'h0: sgl_ptr = 3'h4;
            2'h1: sgl_ptr = 3'h5;
            2'h2: sgl_ptr = 3'h2;
            2'h3: sgl_ptr = 3'h3;
        endcase
        sgl_reg = ds_decode(instr[SGL_DS_LSB +: 4]);
        // Loads name an input register, stores an accumulator
        x_ptr = instr[X_PTR_BIT] ? 3'h5 : 3'h4;
        if (instr[X_DIR_BIT]) begin
            x_reg = instr[X_REG_BIT] ? R_A1 : R_A0;
        end else begin
            x_reg = instr[X_REG_BIT] ? R_X1 : R_X0;
        end
        y_ptr = instr[Y_PTR_BIT] ? 3'h7 : 3'h6;
        if (instr[Y_DIR_BIT]) begin
            y_reg = instr[Y_REG_BIT] ? R_A1 : R_A0;
        end else begin
            y_reg = instr[Y_REG_BIT] ? R_Y1 : R_Y0;
        end
        unique case (op_word[ALU_SX_LSB +: 2])
            2'h0: alu_sx = R_X0;
            2'h1: alu_sx = R_X1;
            2'h2: alu_sx = R_A0;
            2'h3: alu_sx = R_A1;
        endcase
        unique case (op_word[ALU_SY_LSB +: 2])
            2'h0: alu_sy = R_Y0;
            2'h1: alu_sy = R_Y1;
            2'h2: alu_sy = R_M0;
            2'h3: alu_sy = R_M1;
        endcase
        dz_raw = ds_decode(op_word[ALU_DZ_LSB +: 4]);
        alu_dz = (dz_raw == R_A0G || dz_raw == R_A1G) ? R_NONE : dz_raw;
    end
endmodule : dtd_field_decode
`default_nettype wire

// >>> logic/dtd_addr_calc.sv
// Access address and updated pointer for one addressing mode
`default_nettype none
module dtd_addr_calc
    import dtd_pkg::*;
#(
    parameter int AW = 32
) (
    input  wire logic [AW-1:0] ptr,
    input  wire logic [1:0]    mode,
    input  wire logic          long_sz,
    input  wire logic [AW-1:0] index,
    output logic [AW-1:0]      addr,
    output logic [AW-1:0]      next_ptr
);
    logic [AW-1:0] step;

    always_comb begin
        step = long_sz ? STEP_LONG[AW-1:0] : STEP_WORD[AW-1:0];
        addr = ptr;
        next_ptr = ptr;
        unique case (mode)
            MODE_PRE: begin
                addr = ptr - step;
                next_ptr = ptr - step;
            end
            MODE_IND: next_ptr = ptr;
            MODE_POST: next_ptr = ptr + step;
            MODE_IDX: next_ptr = ptr + index;
        endcase
    end
endmodule : dtd_addr_calc
`default_nettype wire

// >>> logic/dtd_top.sv
// DSP data transfer decoder: single and X/Y moves with the DSP register file
`default_nettype none
module dtd_top
    import dtd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    input  wire logic [15:0] op_word,
    input  wire logic [31:0] ptr_r2,
    input  wire logic [31:0] ptr_r3,
    input  wire logic [31:0] ptr_r4,
    input  wire logic [31:0] ptr_r5,
    input  wire logic [31:0] ptr_r6,
    input  wire logic [31:0] ptr_r7,
    input  wire logic [31:0] x_index_reg,
    input  wire logic [31:0] y_index_reg,
    input  wire logic        alu_dc_req,
    input  wire logic        alu_dc_result,
    input  wire logic [15:0] x_data_bus_in,
    input  wire logic [15:0] y_data_bus_in,
    input  wire logic [31:0] load_data_bus_in,
    input  wire dtd_reg_e    rd_sel,
    output logic             x_mem_sel,
    output logic             x_mem_we,
    output logic [31:0]      x_addr,
    output logic [15:0]      x_data_bus_out,
    output logic             y_mem_sel,
    output logic             y_mem_we,
    output logic [31:0]      y_addr,
    output logic [15:0]      y_data_bus_out,
    output logic             ld_req,
    output logic             ld_we,
    output logic             ld_long,
    output logic [31:0]      load_addr_bus,
    output logic [31:0]      load_data_bus_out,
    output logic             sgl_ptr_we,
    output logic [2:0]       sgl_ptr_num,
    output logic [31:0]      sgl_ptr_val,
    output logic             x_ptr_we,
    output logic [2:0]       x_ptr_num,
    output logic [31:0]      x_ptr_val,
    output logic             y_ptr_we,
    output logic [2:0]       y_ptr_num,
    output logic [31:0]      y_ptr_val,
    output dtd_reg_e         alu_sx_sel,
    output dtd_reg_e         alu_sy_sel,
    output dtd_reg_e         alu_dz_sel,
    output logic             dsp_condition_flag,
    output logic [31:0]      rd_data
);
    // Data registers indexed by the low bits of the id, guards by bit 0
    logic [31:0] dreg [0:7];
    logic [7:0]  grd  [0:1];

    dtd_reg_e    sgl_reg;
    dtd_reg_e    x_reg;
    dtd_reg_e    y_reg;
    dtd_reg_e    dec_sx;
    dtd_reg_e    dec_sy;
    dtd_reg_e    dec_dz;
    logic [2:0]  sgl_pnum;
    logic [2:0]  x_pnum;
    logic [2:0]  y_pnum;
    logic [31:0] sgl_ptr;
    logic [31:0] x_ptr;
    logic [31:0] y_ptr;
    logic [31:0] sgl_acc;
    logic [31:0] sgl_next;
    logic [31:0] x_acc;
    logic [31:0] x_next;
    logic [31:0] y_acc;
    logic [31:0] y_next;
    logic        is_par;
    logic        is_sgl;
    logic        x_act;
    logic        y_act;
    logic [1:0]  sgl_mode;
    logic        sgl_long;
    logic        sgl_store;
    logic [31:0] sgl_wval;
    logic [15:0] x_wval;
    logic [15:0] y_wval;

    // Load pipeline: stage 1 holds the request, stage 2 meets the read data
    logic        p1_sgl;
    logic        p1_long;
    dtd_reg_e    p1_sreg;
    logic        p1_x;
    logic        p1_xreg;
    logic        p1_y;
    logic        p1_yreg;
    logic        p2_sgl;
    logic        p2_long;
    dtd_reg_e    p2_sreg;
    logic        p2_x;
    logic        p2_xreg;
    logic        p2_y;
    logic        p2_yreg;

    function automatic logic [31:0] ptr_pick(input logic [2:0] num, input logic [31:0] r2,
                                             input logic [31:0] r3, input logic [31:0] r4,
                                             input logic [31:0] r5, input logic [31:0] r6,
                                             input logic [31:0] r7);
        case (num)
            3'h2: ptr_pick = r2;
            3'h3: ptr_pick = r3;
            3'h4: ptr_pick = r4;
            3'h5: ptr_pick = r5;
            3'h6: ptr_pick = r6;
            default: ptr_pick = r7;
        endcase
    endfunction : ptr_pick

    dtd_field_decode u_dec (
        .instr   (instr),
        .op_word (op_word),
        .sgl_reg (sgl_reg),
        .sgl_ptr (sgl_pnum),
        .x_ptr   (x_pnum),
        .x_reg   (x_reg),
        .y_ptr   (y_pnum),
        .y_reg   (y_reg),
        .alu_sx  (dec_sx),
        .alu_sy  (dec_sy),
        .alu_dz  (dec_dz)
    );

    always_comb begin
        is_par    = instr_valid && instr[PFX_LSB +: 6] == PFX_PAR;
        is_sgl    = instr_valid && instr[PFX_LSB +: 6] == PFX_SGL;
        // A zero mode field is the idle form and raises no select
        x_act     = is_par && instr[X_MODE_LSB +: 2] != MODE_PRE;
        y_act     = is_par && instr[Y_MODE_LSB +: 2] != MODE_PRE;
        sgl_mode  = instr[SGL_MODE_LSB +: 2];
        sgl_long  = instr[SGL_SIZE_BIT];
        sgl_store = instr[SGL_DIR_BIT];
        sgl_ptr   = ptr_pick(sgl_pnum, ptr_r2, ptr_r3, ptr_r4, ptr_r5, ptr_r6, ptr_r7);
        x_ptr     = ptr_pick(x_pnum, ptr_r2, ptr_r3, ptr_r4, ptr_r5, ptr_r6, ptr_r7);
        y_ptr     = ptr_pick(y_pnum, ptr_r2, ptr_r3, ptr_r4, ptr_r5, ptr_r6, ptr_r7);
        x_wval    = dreg[x_reg[2:0]][31:16];
        y_wval    = dreg[y_reg[2:0]][31:16];
        sgl_wval  = 32'h0000_0000;
        if (sgl_reg == R_A0G || sgl_reg == R_A1G) begin
            // Guard on data bits 0-7, upper bits carry its sign; a word store zeroes bits 16-31
            sgl_wval = {{24{grd[sgl_reg[0]][7]}}, grd[sgl_reg[0]]};
            if (!sgl_long) begin
                sgl_wval[31:16] = 16'h0000;
            end
        end else if (sgl_reg != R_NONE) begin
            sgl_wval = sgl_long ? dreg[sgl_reg[2:0]]
                                : {16'h0000, dreg[sgl_reg[2:0]][31:16]};
        end
    end

    dtd_addr_calc #(.AW(32)) u_sgl_addr (
        .ptr      (sgl_ptr),
        .mode     (sgl_mode),
        .long_sz  (sgl_long),
        .index    (x_index_reg),
        .addr     (sgl_acc),
        .next_ptr (sgl_next)
    );

    // X and Y are word only, so their size input is tied to word
    dtd_addr_calc #(.AW(32)) u_x_addr (
        .ptr      (x_ptr),
        .mode     (instr[X_MODE_LSB +: 2]),
        .long_sz  (1'b0),
        .index    (x_index_reg),
        .addr     (x_acc),
        .next_ptr (x_next)
    );

    dtd_addr_calc #(.AW(32)) u_y_addr (
        .ptr      (y_ptr),
        .mode     (instr[Y_MODE_LSB +: 2]),
        .long_sz  (1'b0),
        .index    (y_index_reg),
        .addr     (y_acc),
        .next_ptr (y_next)
    );

    // X/Y requests on their own buses, issued whatever the parallel condition says
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            x_mem_sel      <= 1'b0;
            x_mem_we       <= 1'b0;
            x_addr         <= RST_DATA;
            x_data_bus_out <= 16'h0000;
            y_mem_sel      <= 1'b0;
            y_mem_we       <= 1'b0;
            y_addr         <= RST_DATA;
            y_data_bus_out <= 16'h0000;
        end else begin
            x_mem_sel <= x_act;
            x_mem_we  <= x_act && instr[X_DIR_BIT];
            y_mem_sel <= y_act;
            y_mem_we  <= y_act && instr[Y_DIR_BIT];
            if (x_act) begin
                x_addr         <= x_acc;
                x_data_bus_out <= x_wval;
            end
            if (y_act) begin
                y_addr         <= y_acc;
                y_data_bus_out <= y_wval;
            end
        end
    end

    // Single transfers share the core load bus and can contend with fetches
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ld_req            <= 1'b0;
            ld_we             <= 1'b0;
            ld_long           <= 1'b0;
            load_addr_bus     <= RST_DATA;
            load_data_bus_out <= RST_DATA;
        end else begin
            ld_req  <= is_sgl;
            ld_we   <= is_sgl && sgl_store;
            ld_long <= is_sgl && sgl_long;
            if (is_sgl) begin
                load_addr_bus     <= sgl_acc;
                load_data_bus_out <= sgl_wval;
            end
        end
    end

    // Pointer write-back to the core, only when the pointer moves
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sgl_ptr_we  <= 1'b0;
            sgl_ptr_num <= 3'h0;
            sgl_ptr_val <= RST_DATA;
            x_ptr_we    <= 1'b0;
            x_ptr_num   <= 3'h0;
            x_ptr_val   <= RST_DATA;
            y_ptr_we    <= 1'b0;
            y_ptr_num   <= 3'h0;
            y_ptr_val   <= RST_DATA;
        end else begin
            sgl_ptr_we <= is_sgl && sgl_mode != MODE_IND;
            x_ptr_we   <= x_act && instr[X_MODE_LSB +: 2] != MODE_IND;
            y_ptr_we   <= y_act && instr[Y_MODE_LSB +: 2] != MODE_IND;
            if (is_sgl) begin
                sgl_ptr_num <= sgl_pnum;
                sgl_ptr_val <= sgl_next;
            end
            if (x_act) begin
                x_ptr_num <= x_pnum;
                x_ptr_val <= x_next;
            end
            if (y_act) begin
                y_ptr_num <= y_pnum;
                y_ptr_val <= y_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p1_sgl  <= 1'b0;
            p1_long <= 1'b0;
            p1_sreg <= R_NONE;
            p1_x    <= 1'b0;
            p1_xreg <= 1'b0;
            p1_y    <= 1'b0;
            p1_yreg <= 1'b0;
            p2_sgl  <= 1'b0;
            p2_long <= 1'b0;
            p2_sreg <= R_NONE;
            p2_x    <= 1'b0;
            p2_xreg <= 1'b0;
            p2_y    <= 1'b0;
            p2_yreg <= 1'b0;
        end else begin
            p1_sgl  <= is_sgl && !sgl_store && sgl_reg != R_NONE;
            p1_long <= sgl_long;
            p1_sreg <= sgl_reg;
            p1_x    <= x_act && !instr[X_DIR_BIT];
            p1_xreg <= instr[X_REG_BIT];
            p1_y    <= y_act && !instr[Y_DIR_BIT];
            p1_yreg <= instr[Y_REG_BIT];
            p2_sgl  <= p1_sgl;
            p2_long <= p1_long;
            p2_sreg <= p1_sreg;
            p2_x    <= p1_x;
            p2_xreg <= p1_xreg;
            p2_y    <= p1_y;
            p2_yreg <= p1_yreg;
        end
    end

    // Register file; a store that reads a register still in the load pipe sees the old value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                dreg[i] <= RST_DATA;
            end
            grd[0] <= RST_GUARD;
            grd[1] <= RST_GUARD;
        end else begin
            if (p2_x) begin
                dreg[{2'b00, p2_xreg}] <= {x_data_bus_in, 16'h0000};
            end
            if (p2_y) begin
                dreg[{2'b01, p2_yreg}] <= {y_data_bus_in, 16'h0000};
            end
            if (p2_sgl) begin
                if (p2_sreg == R_A0G || p2_sreg == R_A1G) begin
                    grd[p2_sreg[0]] <= load_data_bus_in[7:0];
                end else if (p2_long) begin
                    dreg[p2_sreg[2:0]] <= load_data_bus_in;
                    if (p2_sreg == R_A0 || p2_sreg == R_A1) begin
                        grd[p2_sreg[0]] <= {8{load_data_bus_in[31]}};
                    end
                end else begin
                    dreg[p2_sreg[2:0]] <= {load_data_bus_in[15:0], 16'h0000};
                    if (p2_sreg == R_A0 || p2_sreg == R_A1) begin
                        grd[p2_sreg[0]] <= {8{load_data_bus_in[15]}};
                    end
                end
            end
        end
    end

    // Transfers never move the flag; only a marked arithmetic op does
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dsp_condition_flag <= RST_DC;
        end else if (alu_dc_req && !is_par && !is_sgl) begin
            dsp_condition_flag <= alu_dc_result;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alu_sx_sel <= R_NONE;
            alu_sy_sel <= R_NONE;
            alu_dz_sel <= R_NONE;
            rd_data    <= RST_DATA;
        end else begin
            if (is_par) begin
                alu_sx_sel <= dec_sx;
                alu_sy_sel <= dec_sy;
                alu_dz_sel <= dec_dz;
            end
            if (rd_sel == R_A0G || rd_sel == R_A1G) begin
                rd_data <= {24'h000000, grd[rd_sel[0]]};
            end else if (rd_sel == R_NONE) begin
                rd_data <= RST_DATA;
            end else begin
                rd_data <= dreg[rd_sel[2:0]];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_x_idle_nosel: assert property (
        (is_par && instr[X_MODE_LSB +: 2] == MODE_PRE) |=> !x_mem_sel)
        else $error("X select raised for idle X field");
    a_x_post_step: assert property (
        (is_par && instr[X_MODE_LSB +: 2] == MODE_POST)
        |=> x_mem_sel && x_ptr_we && x_ptr_val == x_addr + 32'h2)
        else $error("X post-increment wrong");
    a_sgl_ptr_map: assert property (
        (is_sgl && sgl_mode == MODE_IND && instr[SGL_AA_LSB +: 2] == 2'h2)
        |=> ld_req && load_addr_bus == $past(ptr_r2))
        else $error("Single pointer code 2 not mapped to R2");
    a_word_pre_dec: assert property (
        (is_sgl && sgl_mode == MODE_PRE && !sgl_long)
        |=> load_addr_bus == $past(sgl_ptr) - 32'h2 && sgl_ptr_val == load_addr_bus)
        else $error("Word pre-decrement wrong");
    a_long_post_inc: assert property (
        (is_sgl && sgl_mode == MODE_POST && sgl_long)
        |=> ld_long && sgl_ptr_val == $past(sgl_ptr) + 32'h4)
        else $error("Longword post-increment wrong");
    a_idx_update: assert property (
        (is_sgl && sgl_mode == MODE_IDX)
        |=> load_addr_bus == $past(sgl_ptr)
            && sgl_ptr_val == $past(sgl_ptr) + $past(x_index_reg))
        else $error("Indexed pointer update wrong");
    a_x_store_upper: assert property (
        (x_act && instr[X_DIR_BIT]) |=> x_mem_we && x_data_bus_out == $past(x_wval))
        else $error("X store data not upper half");
    a_word_load_fill: assert property (
        (p2_sgl && !p2_long && p2_sreg == R_A0)
        |=> dreg[6] == {$past(load_data_bus_in[15:0]), 16'h0000}
            && grd[0] == {8{$past(load_data_bus_in[15])}})
        else $error("Word load into accumulator wrong");
    a_dc_hold: assert property (
        (is_par || is_sgl) |=> $stable(dsp_condition_flag))
        else $error("Condition flag changed by a transfer");
    a_load_latency: assert property (
        (is_sgl && !sgl_store && sgl_reg != R_NONE) |=> ld_req && !ld_we ##1 p2_sgl)
        else $error("Single load not written two cycles after issue");

    c_long_store: cover property (is_sgl && sgl_long && sgl_store ##1 ld_we);
    c_x_post_load: cover property (p1_x ##1 p2_x);
    c_par_both: cover property (x_act && y_act);
    c_guard_load: cover property (p2_sgl && p2_sreg == R_A1G);
endmodule : dtd_top
`default_nettype wire

// >>> dv/dtd_mem_model.sv
// Memory far side: answers reads in the cycle after each request
`default_nettype none
module dtd_mem_model (
    input  wire logic        clk,
    input  wire logic        ld_req,
    input  wire logic        ld_we,
    input  wire logic [31:0] load_addr_bus,
    input  wire logic        x_mem_sel,
    input  wire logic        x_mem_we,
    input  wire logic [31:0] x_addr,
    output logic [31:0]      load_data_bus_in,
    output logic [15:0]      x_data_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        load_data_bus_in = 32'h0;
        x_data_bus_in = 16'h0;
    end
    // Outside the answer cycle the data is inverted so a late sample is caught
    always @(posedge clk) begin
        load_data_bus_in <= (ld_req && !ld_we) ?
            {~load_addr_bus[15:0], load_addr_bus[15:0] ^ 16'h8765} : ~load_data_bus_in;
        x_data_bus_in <= (x_mem_sel && !x_mem_we) ? x_addr[15:0] ^ 16'h5555 : ~x_data_bus_in;
    end
endmodule : dtd_mem_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the data transfer decoder
`default_nettype none
module testbench
    import dtd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, instr_valid, alu_dc_req, alu_dc_result;
    logic [15:0] instr, op_word, x_data_bus_in, y_data_bus_in, x_data_bus_out, y_data_bus_out;
    logic [31:0] ptr_r2, ptr_r3, ptr_r4, ptr_r5, ptr_r6, ptr_r7, x_index_reg, y_index_reg;
    logic [31:0] load_data_bus_in, x_addr, y_addr, load_addr_bus, load_data_bus_out;
    logic [31:0] sgl_ptr_val, x_ptr_val, y_ptr_val, rd_data;
    logic x_mem_sel, x_mem_we, y_mem_sel, y_mem_we, ld_req, ld_we, ld_long;
    logic sgl_ptr_we, x_ptr_we, y_ptr_we, dsp_condition_flag;
    logic [2:0] sgl_ptr_num, x_ptr_num, y_ptr_num;
    dtd_reg_e rd_sel, alu_sx_sel, alu_sy_sel, alu_dz_sel;
    int bad_count = 0;
    int num_checks = 0;

    dtd_top u_dtd_top (.clk, .rst_n, .instr_valid, .instr, .op_word, .ptr_r2, .ptr_r3,
        .ptr_r4, .ptr_r5, .ptr_r6, .ptr_r7, .x_index_reg, .y_index_reg, .alu_dc_req,
        .alu_dc_result, .x_data_bus_in, .y_data_bus_in, .load_data_bus_in, .rd_sel,
        .x_mem_sel, .x_mem_we, .x_addr, .x_data_bus_out, .y_mem_sel, .y_mem_we, .y_addr,
        .y_data_bus_out, .ld_req, .ld_we, .ld_long, .load_addr_bus, .load_data_bus_out,
        .sgl_ptr_we, .sgl_ptr_num, .sgl_ptr_val, .x_ptr_we, .x_ptr_num, .x_ptr_val,
        .y_ptr_we, .y_ptr_num, .y_ptr_val, .alu_sx_sel, .alu_sy_sel, .alu_dz_sel,
        .dsp_condition_flag, .rd_data);
    dtd_mem_model u_dtd_mem_model (.clk, .ld_req, .ld_we, .load_addr_bus, .x_mem_sel,
        .x_mem_we, .x_addr, .load_data_bus_in, .x_data_bus_in);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Returns at the falling edge of the request cycle; more keeps valid up for the next word
    task automatic issue(input logic [15:0] w, input bit more = 1'b0);
        instr = w;
        instr_valid = 1'b1;
        @(negedge clk);
        if (!more) begin
            instr_valid = 1'b0;
        end
    endtask : issue

    task automatic rd(input dtd_reg_e s, input logic [31:0] exp);
        rd_sel = s;
        repeat (2) @(negedge clk);
        chk(rd_data, exp);
    endtask : rd

    // Word post-increment load into accum_0, with a flag request on the same cycle
    task automatic t_single_load();
        alu_dc_req = 1'b1;
        alu_dc_result = 1'b1;
        issue(16'hf478);
        alu_dc_req = 1'b0;
        chk(ld_req, 1'b1);
        chk(load_addr_bus, 32'h400);
        chk(sgl_ptr_num, 3'h4);
        chk(sgl_ptr_val, 32'h402);
        chk(dsp_condition_flag, 1'b0);
        repeat (2) @(negedge clk);
        rd(R_A0, 32'h8365_0000);
        rd(R_A0G, 32'hff);
        alu_dc_req = 1'b1;
        @(negedge clk);
        alu_dc_req = 1'b0;
        chk(dsp_condition_flag, 1'b1);
    endtask : t_single_load

    // Back-to-back single stores and loads through every addressing mode
    task automatic t_single_store();
        issue(16'hf773, 1'b1);
        chk(ld_long, 1'b1);
        chk(ld_we, 1'b1);
        chk(load_addr_bus, 32'h7fc);
        chk(load_data_bus_out, 32'h8365_0000);
        issue(16'hf67d, 1'b1);
        chk(ld_long, 1'b0);
        chk(sgl_ptr_num, 3'h2);
        chk(load_addr_bus, 32'h100);
        chk(load_data_bus_out[15:0], 16'h8365);
        chk(sgl_ptr_val, 32'h106);
        issue(16'hf551, 1'b1);
        chk(load_addr_bus, 32'h2fe);
        chk(sgl_ptr_val, 32'h2fe);
        chk(load_data_bus_out, 32'h0000_0000);
        issue(16'hf6c6, 1'b1);
        chk(load_addr_bus, 32'h100);
        issue(16'hf45a);
        chk(load_addr_bus, 32'h400);
        chk(sgl_ptr_val, 32'h404);
        repeat (2) @(negedge clk);
        rd(R_M0, 32'hfeff_8665);
        rd(R_A1G, 32'hff);
    endtask : t_single_store

    task automatic t_x_mem();
        issue(16'hf208);
        chk(x_mem_sel, 1'b1);
        chk(x_addr, 32'h300);
        chk(x_ptr_val, 32'h302);
        chk(y_mem_sel, 1'b0);
        repeat (2) @(negedge clk);
        rd(R_X0, 32'h5655_0000);
        issue(16'hf02c, 1'b1);
        chk(x_mem_we, 1'b1);
        chk(x_ptr_num, 3'h4);
        chk(x_data_bus_out, 16'h8365);
        chk(x_ptr_val, 32'h406);
        issue(16'hf000, 1'b1);
        chk(x_mem_sel, 1'b0);
        issue(16'hf408);
        repeat (2) @(negedge clk);
        rd(R_A1, 32'hfbff_8365);
        op_word = 16'h00ed;
        issue(16'hf3e7);
        chk(x_data_bus_out, 16'hfbff);
        chk(x_mem_sel & x_mem_we & ~x_ptr_we, 1'b1);
        chk(y_mem_sel & ~y_mem_we, 1'b1);
        chk(y_addr, 32'h700);
        chk(y_ptr_num, 3'h7);
        chk(y_ptr_val, 32'h708);
        chk(alu_sx_sel, R_A1);
        chk(alu_sy_sel, R_M0);
        chk(alu_dz_sel, R_NONE);
        repeat (2) @(negedge clk);
        rd(R_Y1, 32'h1234_0000);
    endtask : t_x_mem

    initial begin
        rst_n = 1'b0;
        {instr_valid, alu_dc_req, alu_dc_result} = 3'h0;
        {instr, op_word, y_data_bus_in} = 48'h1234;
        {ptr_r2, ptr_r3, ptr_r4, ptr_r5} = {32'h100, 32'h800, 32'h400, 32'h300};
        {ptr_r6, ptr_r7, x_index_reg, y_index_reg} = {32'h600, 32'h700, 32'h6, 32'h8};
        rd_sel = R_NONE;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_single_load();
        t_single_store();
        t_x_mem();
        give_verdict();
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        #100us;
        bad_count++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
